// ---- verilog/can_fm_pkg.sv ----
/*
  Shared constants and carriers for the CAN functional-mode resource block.
  Assumes a 40 MHz system clock and an AXI4-Lite master on the same clock.
*/
package can_fm_pkg;
  // ==========================================================
  // Resource counts
  localparam int ID_W = 29;
  localparam int NFILT = 16;
  localparam int NRX = 8;
  localparam int NTX = 9;
  localparam int NXTRA = 6;
  localparam int FIFO_DEPTH = 16;
  localparam int ADDR_W = 12;

  // ==========================================================
  // Functional modes, receive modes and mask selects
  localparam logic [1:0] MODE_LEGACY = 2'h0;
  localparam logic [1:0] MODE_ENH = 2'h1;
  localparam logic [1:0] MODE_FIFO = 2'h2;
  localparam logic [1:0] RX_MODE_ANY = 2'h3;
  localparam logic [1:0] MSEL_M0 = 2'h0;
  localparam logic [1:0] MSEL_M1 = 2'h1;
  localparam logic [1:0] MSEL_F15 = 2'h2;

  // ==========================================================
  // Register map, byte addresses
  localparam logic [ADDR_W-1:0] OFF_MODE = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_RXCTL = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_BUFCFG = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_TXREQ = 12'h00c;
  localparam logic [ADDR_W-1:0] OFF_RXFULL = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_STAT = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_MASK0 = 12'h020;
  localparam logic [ADDR_W-1:0] OFF_MASK1 = 12'h024;
  localparam logic [5:0] RGN_CTRL = 6'h00;
  localparam logic [5:0] RGN_FILT = 6'h01;
  localparam logic [5:0] RGN_LINK = 6'h02;
  localparam logic [5:0] RGN_BUFID = 6'h03;

  // ==========================================================
  // Field positions, legacy masks and response codes
  localparam int MODE_F15M_BIT = 4;
  localparam int BUFCFG_RTR_LSB = 8;
  localparam int LINK_MSEL_LSB = 3;
  localparam logic [NTX-1:0] TX_LEGACY_MASK = 9'h007;
  localparam logic [NRX-1:0] RX_LEGACY_MASK = 8'h03;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Received frame as delivered by the protocol engine
  typedef struct packed {
    logic rtr;
    logic err;
    logic [3:0] dlc;
    logic [ID_W-1:0] id;
  } frame_t;
endpackage : can_fm_pkg

// ---- verilog/can_functional_mode_resources.sv ----
/*
  Functional-mode resource manager: filters, masks, buffer ownership,
  auto remote answer, a frame FIFO and the AXI4-Lite register slave.
  Assumes frames arrive from a protocol engine on the same clock.
*/
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
// How it works
// - Three functional modes beside operating modes
// - Every reset leaves functional mode zero
// - Mode zero offers three transmit buffers
// - Mode zero: two receive buffers, two masks
// - Mode zero: filters 0-1 rx0, 2-5 rx1
// - Mode one: sixteen filters, two masks
// - Filter fifteen may act as mask
// - Six extra buffers, each transmit or receive
// - Extra buffers answer remote requests automatically
// - Fourteen filters freely linked to buffer, mask
// - Receive mode 11 accepts anything, errors too (the code does so in mode zero only)
`timescale 1ns/10ps

// ==========================================================
// Frame FIFO
module can_fm_fifo #(
  parameter int W = 35,
  parameter int DEPTH = 16
) (
  // Clock and control
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Fill side
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  // Drain side
  output logic o_valid,
  output logic [W-1:0] o_data,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
    logic vld;
  } fst_t;
  fst_t st_reg;
  fst_t st_next;
  logic push;
  logic pop;

  // Pointers wrap by width, so depth must be a power of two
  always_comb begin
    st_next = st_reg;
    push = i_valid && st_reg.rdy;
    pop = st_reg.vld && i_ready;
    if (push) begin
      st_next.mem[st_reg.wp] = i_data;
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = st_reg.rp + 1'b1;
    end
    if (push && !pop) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
    st_next.rdy = (st_next.cnt != (AW+1)'(DEPTH));
    st_next.vld = (st_next.cnt != '0);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  assign o_ready = st_reg.rdy;
  assign o_valid = st_reg.vld;
  assign o_data = st_reg.mem[st_reg.rp];
endmodule : can_fm_fifo

// ==========================================================
// Resource manager top
module can_functional_mode_resources (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Received frames
  input wire logic i_frame_valid,
  input wire can_fm_pkg::frame_t i_frame,
  output logic o_frame_ready,
  // Transmit requests
  input wire logic [can_fm_pkg::NTX-1:0] i_tx_done,
  output logic [can_fm_pkg::NTX-1:0] o_tx_req,
  // Status
  output logic [can_fm_pkg::NRX-1:0] o_rx_full,
  output logic [1:0] o_mode,
  // AXI4-Lite write
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [can_fm_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [can_fm_pkg::ADDR_W-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp
);
  import can_fm_pkg::*;

  typedef struct packed {
    logic [1:0] mode;
    logic f15_mask;
    logic [3:0] rx_mode;
    logic [NXTRA-1:0] xdir;
    logic [NXTRA-1:0] xrtr;
    logic [NTX-1:0] txreq;
    logic [NRX-1:0] rxfull;
    logic [NFILT-1:0][ID_W-1:0] filt;
    logic [NFILT-1:0][4:0] link;
    logic [1:0][ID_W-1:0] mask;
    logic [NRX-1:0][ID_W-1:0] bufid;
    logic [4:0] last_hit;
    logic [3:0] last_dlc;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } st_t;
  st_t st_reg;
  st_t st_next;

  frame_t fr;
  logic fr_valid;
  logic pop;
  logic enh;
  logic [NFILT-1:0] hit;
  logic [NFILT-1:0][2:0] tbuf;
  logic store_en;
  logic [2:0] store_buf;
  logic [NTX-1:0] auto_set;
  logic wr_fire;
  logic [31:0] rd_val;
  logic rd_ok;
  logic wr_ok;

  // ==========================================================
  // Frame FIFO: a full receive buffer stalls draining
  can_fm_fifo #(.W($bits(frame_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_valid(i_frame_valid),
    .i_data(i_frame),
    .o_ready(o_frame_ready),
    .o_valid(fr_valid),
    .o_data(fr),
    .i_ready(pop)
  );

  // Mode two is held to mode one behaviour
  assign enh = (st_reg.mode != MODE_LEGACY);

  // ==========================================================
  // Per-filter compare: target buffer, mask choice, enable
  for (genvar i = 0; i < NFILT; i++) begin : g_filt
    logic en;
    logic [1:0] msel;
    logic [ID_W-1:0] mk;
    always_comb begin
      en = 1'b0;
      msel = MSEL_M0;
      tbuf[i] = 3'h0;
      if (!enh) begin
        en = (i < 6);
        msel = (i < 2) ? MSEL_M0 : MSEL_M1;
        tbuf[i] = (i < 2) ? 3'h0 : 3'h1;
      end else if (i < 2) begin
        en = 1'b1;
      end else begin
        en = !(i == NFILT-1 && st_reg.f15_mask);
        msel = st_reg.link[i][LINK_MSEL_LSB +: 2];
        tbuf[i] = st_reg.link[i][2:0];
      end
      if (enh && msel == MSEL_F15 && st_reg.f15_mask) begin
        mk = st_reg.filt[NFILT-1];
      end else if (msel == MSEL_M1) begin
        mk = st_reg.mask[1];
      end else begin
        mk = st_reg.mask[0];
      end
      hit[i] = en && (((fr.id ^ st_reg.filt[i]) & mk) == '0);
    end
  end

  // ==========================================================
  // Register read decode; unmapped answers SLVERR with zero
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (i_araddr[11:6])
      RGN_CTRL: begin
        unique case ({i_araddr[5:2], 2'b00})
          OFF_MODE[5:0]: begin
            rd_val = {27'h0, st_reg.f15_mask, 2'h0, st_reg.mode};
          end
          OFF_RXCTL[5:0]: rd_val = {28'h0, st_reg.rx_mode};
          OFF_BUFCFG[5:0]: begin
            rd_val = {18'h0, st_reg.xrtr, 2'h0, st_reg.xdir};
          end
          OFF_TXREQ[5:0]: rd_val = {23'h0, st_reg.txreq};
          OFF_RXFULL[5:0]: rd_val = {24'h0, st_reg.rxfull};
          OFF_STAT[5:0]: begin
            rd_val = {23'h0, st_reg.last_dlc, st_reg.last_hit};
          end
          OFF_MASK0[5:0]: rd_val = {3'h0, st_reg.mask[0]};
          OFF_MASK1[5:0]: rd_val = {3'h0, st_reg.mask[1]};
          default: rd_ok = 1'b0;
        endcase
      end
      RGN_FILT: rd_val = {3'h0, st_reg.filt[i_araddr[5:2]]};
      RGN_LINK: rd_val = {27'h0, st_reg.link[i_araddr[5:2]]};
      RGN_BUFID: begin
        if (!i_araddr[5]) begin
          rd_val = {3'h0, st_reg.bufid[i_araddr[4:2]]};
        end else begin
          rd_ok = 1'b0;
        end
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // Byte-lane merge for narrow fields
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  assign wr_fire = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;

  // ==========================================================
  // Next state: acceptance, buffer flags, bus slave
  always_comb begin
    logic [31:0] wv;
    logic [31:0] old;
    logic [3:0] ri;
    logic got;
    logic [3:0] hidx;
    logic [2:0] t;
    wv = 32'h0;
    old = 32'h0;
    ri = st_reg.awaddr[5:2];
    got = 1'b0;
    hidx = 4'h0;
    t = 3'h0;
    st_next = st_reg;
    store_en = 1'b0;
    store_buf = 3'h0;
    auto_set = '0;
    pop = 1'b0;
    wr_ok = 1'b1;
    // Lowest numbered hit wins
    for (int i = NFILT-1; i >= 0; i--) begin
      if (hit[i]) begin
        got = 1'b1;
        hidx = 4'(i);
        t = tbuf[i];
      end
    end
    if (fr_valid) begin
      if (!enh && st_reg.rx_mode[1:0] == RX_MODE_ANY) begin
        store_buf = 3'h0;
        store_en = 1'b1;
      end else if (!enh && st_reg.rx_mode[3:2] == RX_MODE_ANY) begin
        store_buf = 3'h1;
        store_en = 1'b1;
      end else if (got && !fr.err) begin
        store_buf = t;
        if (t >= 3'h2 && st_reg.xdir[t-3'h2]) begin
          // A transmit-owned extra buffer only answers remotes
          // Widened first: a 3-bit sum would wrap extra 5 onto bit 0
          auto_set[4'(t) + 4'h1] = fr.rtr && st_reg.xrtr[t-3'h2];
        end else begin
          store_en = 1'b1;
        end
      end
      // Full target holds the frame in the FIFO
      pop = !(store_en && st_reg.rxfull[store_buf]);
      store_en = store_en && pop;
    end
    if (store_en) begin
      st_next.bufid[store_buf] = fr.id;
      st_next.last_hit = {!got, hidx};
      st_next.last_dlc = fr.dlc;
    end
    // Completion clears, hardware set wins
    st_next.txreq = st_reg.txreq & ~i_tx_done;
    // Write channel: address and data in either order
    if (i_awvalid && st_reg.awready) begin
      st_next.aw_held = 1'b1;
      st_next.awaddr = i_awaddr;
    end
    if (i_wvalid && st_reg.wready) begin
      st_next.w_held = 1'b1;
      st_next.wdata = i_wdata;
      st_next.wstrb = i_wstrb;
    end
    if (wr_fire) begin
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      wv = st_reg.wdata;
      unique case (st_reg.awaddr[11:6])
        RGN_CTRL: begin
          unique case ({st_reg.awaddr[5:2], 2'b00})
            OFF_MODE[5:0]: begin
              old = {27'h0, st_reg.f15_mask, 2'h0, st_reg.mode};
              wv = merge(old, wv, st_reg.wstrb);
              st_next.mode = wv[1:0];
              st_next.f15_mask = wv[MODE_F15M_BIT];
            end
            OFF_RXCTL[5:0]: begin
              wv = merge({28'h0, st_reg.rx_mode}, wv, st_reg.wstrb);
              st_next.rx_mode = wv[3:0];
            end
            OFF_BUFCFG[5:0]: begin
              old = {18'h0, st_reg.xrtr, 2'h0, st_reg.xdir};
              wv = merge(old, wv, st_reg.wstrb);
              st_next.xdir = wv[NXTRA-1:0];
              st_next.xrtr = wv[BUFCFG_RTR_LSB +: NXTRA];
            end
            OFF_TXREQ[5:0]: begin
              wv = merge(32'h0, wv, st_reg.wstrb);
              st_next.txreq = st_next.txreq | wv[NTX-1:0];
            end
            OFF_RXFULL[5:0]: begin
              wv = merge(32'h0, wv, st_reg.wstrb);
              st_next.rxfull = st_reg.rxfull & ~wv[NRX-1:0];
            end
            OFF_STAT[5:0]: wr_ok = 1'b1;
            OFF_MASK0[5:0]: begin
              wv = merge({3'h0, st_reg.mask[0]}, wv, st_reg.wstrb);
              st_next.mask[0] = wv[ID_W-1:0];
            end
            OFF_MASK1[5:0]: begin
              wv = merge({3'h0, st_reg.mask[1]}, wv, st_reg.wstrb);
              st_next.mask[1] = wv[ID_W-1:0];
            end
            default: wr_ok = 1'b0;
          endcase
        end
        RGN_FILT: begin
          wv = merge({3'h0, st_reg.filt[ri]}, wv, st_reg.wstrb);
          st_next.filt[ri] = wv[ID_W-1:0];
        end
        RGN_LINK: begin
          wv = merge({27'h0, st_reg.link[ri]}, wv, st_reg.wstrb);
          st_next.link[ri] = wv[4:0];
        end
        default: wr_ok = 1'b0;
      endcase
      st_next.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (st_reg.bvalid && i_bready) begin
      st_next.bvalid = 1'b0;
    end
    st_next.awready = !st_next.aw_held && !st_next.bvalid;
    st_next.wready = !st_next.w_held && !st_next.bvalid;
    // Read channel: one outstanding read
    if (i_arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = rd_val;
      st_next.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (st_reg.rvalid && i_rready) begin
      st_next.rvalid = 1'b0;
    end
    st_next.arready = !st_next.rvalid;
    // Hardware sets land after software clears
    st_next.txreq = st_next.txreq | auto_set;
    if (store_en) begin
      st_next.rxfull[store_buf] = 1'b1;
    end
    // Legacy mode hides the extra buffers
    if (st_next.mode == MODE_LEGACY) begin
      st_next.txreq = st_next.txreq & TX_LEGACY_MASK;
      st_next.rxfull = st_next.rxfull & RX_LEGACY_MASK;
    end else begin
      st_next.txreq = st_next.txreq & {st_next.xdir, 3'h7};
      st_next.rxfull = st_next.rxfull & {~st_next.xdir, 2'h3};
    end
  end

  // State register; reset lands in legacy mode
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  assign o_tx_req = st_reg.txreq;
  assign o_rx_full = st_reg.rxfull;
  assign o_mode = st_reg.mode;
  assign o_awready = st_reg.awready;
  assign o_wready = st_reg.wready;
  assign o_bvalid = st_reg.bvalid;
  assign o_bresp = st_reg.bresp;
  assign o_arready = st_reg.arready;
  assign o_rvalid = st_reg.rvalid;
  assign o_rdata = st_reg.rdata;
  assign o_rresp = st_reg.rresp;

  // ==========================================================
  // Checks
  a_reset_mode_zero: assert property (@(posedge i_clk)
    $past(i_rst) && !i_rst |-> o_mode == MODE_LEGACY)
    else $error("mode not zero after reset");
  a_legacy_tx_three: assert property (@(posedge i_clk)
    disable iff (i_rst) o_mode == MODE_LEGACY |-> o_tx_req[8:3] == '0)
    else $error("extra tx request in legacy mode");
  a_legacy_rx_two: assert property (@(posedge i_clk)
    disable iff (i_rst) o_mode == MODE_LEGACY |-> o_rx_full[7:2] == '0)
    else $error("extra rx buffer used in legacy mode");
  a_legacy_filt_six: assert property (@(posedge i_clk)
    disable iff (i_rst) !enh |-> hit[15:6] == '0)
    else $error("legacy filter above five matched");
  a_enh_filt_hit: assert property (@(posedge i_clk)
    disable iff (i_rst) enh && st_reg.link[9][4:3] == MSEL_M0 &&
    (((fr.id ^ st_reg.filt[9]) & st_reg.mask[0]) == '0) |-> hit[9])
    else $error("enhanced filter nine missed");
  a_f15_mask_off: assert property (@(posedge i_clk)
    disable iff (i_rst) enh && st_reg.f15_mask |-> !hit[15])
    else $error("filter fifteen matched while a mask");
  a_rtr_auto_req: assert property (@(posedge i_clk)
    disable iff (i_rst) i_ce && auto_set != '0 |=>
    (o_tx_req & $past(auto_set)) == $past(auto_set))
    else $error("remote request not answered");
  a_store_sets: assert property (@(posedge i_clk)
    disable iff (i_rst) i_ce && store_en |=>
    o_rx_full[$past(store_buf)] ##1 o_rx_full[$past(store_buf, 2)])
    else $error("stored buffer not flagged full");
  a_err_any_only: assert property (@(posedge i_clk)
    disable iff (i_rst) store_en && fr.err |->
    !enh && (st_reg.rx_mode[1:0] == RX_MODE_ANY ||
    st_reg.rx_mode[3:2] == RX_MODE_ANY))
    else $error("errored frame stored without accept-all");
  a_mode_write: assert property (@(posedge i_clk)
    disable iff (i_rst) i_ce && wr_fire && st_reg.wstrb[0] &&
    st_reg.awaddr == OFF_MODE |=> o_mode == $past(st_reg.wdata[1:0]))
    else $error("mode write not applied");
endmodule : can_functional_mode_resources

// ---- testbench/can_node_model.sv ----
/*
  Model of the other CAN nodes: offers received frames and reports
  finished transmissions. Assumes it shares the block's i_clk.
*/
`timescale 1ns/10ps
module can_node_model (
  // Clock
  input wire logic i_clk,
  // From the block
  input wire logic i_frame_ready,
  input wire logic [can_fm_pkg::NTX-1:0] i_tx_req,
  // To the block
  output can_fm_pkg::frame_t o_frame,
  output logic o_frame_valid,
  output logic [can_fm_pkg::NTX-1:0] o_tx_done
);
  import can_fm_pkg::*;

  // ==========================================================
  // Idle levels
  initial begin
    o_frame = '0;
    o_frame_valid = 1'b0;
    o_tx_done = '0;
  end

  // Offer a frame, hold it until taken or the limit runs out
  task automatic send(input frame_t f, input int lim, output bit ok);
    ok = 1'b0;
    @(posedge i_clk);
    o_frame_valid <= 1'b1;
    o_frame <= f;
    for (int i = 0; i < lim && !ok; i++) begin
      @(posedge i_clk);
      ok = i_frame_ready;
    end
    // Released payload inverted, so no one leans on a stale frame
    o_frame_valid <= 1'b0;
    o_frame <= ~f;
  endtask : send

  // Report done only for buffers that really had a request
  task automatic tx_finish(input logic [NTX-1:0] m);
    @(posedge i_clk);
    o_tx_done <= m & i_tx_req;
    @(posedge i_clk);
    o_tx_done <= '0;
  endtask : tx_finish
endmodule : can_node_model

// ---- testbench/tb.sv ----
/*
  Self-checking bench of the functional-mode resource block.
  Assumes the package map and the node model beside it.
*/
`timescale 1ns/10ps
module tb;
  import can_fm_pkg::*;
  // ==========================================================
  // Clock, reset, bus and counters
  localparam int CEIL = 20000;
  localparam logic [ADDR_W-1:0] FILT = 12'h040;
  localparam logic [ADDR_W-1:0] LINK = 12'h080;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_frame_ready;
  logic frame_valid;
  logic [1:0] o_bresp, o_rresp, o_mode;
  logic [31:0] o_rdata;
  logic [NTX-1:0] o_tx_req, tx_done;
  logic [NRX-1:0] o_rx_full;
  frame_t frame;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  always #12.5 i_clk = ~i_clk;

  // ==========================================================
  // Block and far side
  can_functional_mode_resources dut_u (.i_clk(i_clk), .i_rst(i_rst),
    .i_ce(1'b1), .i_frame_valid(frame_valid), .i_frame(frame),
    .o_frame_ready(o_frame_ready), .i_tx_done(tx_done),
    .o_tx_req(o_tx_req), .o_rx_full(o_rx_full), .o_mode(o_mode),
    .i_awvalid(awvalid), .o_awready(o_awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(o_wready), .i_wdata(wdata),
    .i_wstrb(4'hf), .o_bvalid(o_bvalid), .i_bready(bready),
    .o_bresp(o_bresp), .i_arvalid(arvalid), .o_arready(o_arready),
    .i_araddr(araddr), .o_rvalid(o_rvalid), .i_rready(rready),
    .o_rdata(o_rdata), .o_rresp(o_rresp));
  can_node_model node_u (.i_clk(i_clk), .i_frame_ready(o_frame_ready),
    .i_tx_req(o_tx_req), .o_frame(frame), .o_frame_valid(frame_valid),
    .o_tx_done(tx_done));

  // ==========================================================
  // Shared tasks
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // A hang counts as a mismatch
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == CEIL) begin
      fails++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick

  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    @(posedge i_clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    forever begin
      @(posedge i_clk);
      if (awvalid && o_awready) awvalid <= 1'b0;
      if (wvalid && o_wready) wvalid <= 1'b0;
      if (o_bvalid) begin
        r = o_bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : axi_wr

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
  endtask : wr

  task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge i_clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    forever begin
      @(posedge i_clk);
      if (arvalid && o_arready) arvalid <= 1'b0;
      if (o_rvalid) begin
        d = o_rdata;
        r = o_rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : axi_rd

  // Offer one frame and let the routing settle
  task automatic put(input logic [ID_W-1:0] id, input logic rtr,
                     input logic err);
    bit ok;
    node_u.send('{rtr: rtr, err: err, dlc: 4'h2, id: id}, 100, ok);
    tick(4);
  endtask : put

  // ==========================================================
  // Scenarios
  task automatic t_reset_map();
    logic [31:0] d;
    logic [1:0] r;
    chk("o_mode", o_mode, 2'h0);
    axi_rd(OFF_MODE, d, r);
    chk("mode reg", d, 32'h0);
    axi_rd(12'hffc, d, r);
    chk("unmapped resp", r, RESP_SLVERR);
    chk("unmapped data", d, 32'h0);
    axi_wr(12'h0c0, 32'h1, r);
    chk("id write resp", r, RESP_SLVERR);
  endtask : t_reset_map

  // Only the three legacy transmit buffers may request
  task automatic t_legacy_tx();
    wr(OFF_TXREQ, 32'h1ff);
    tick(2);
    chk("tx_req", o_tx_req, 9'h007);
    node_u.tx_finish(9'h1ff);
    tick(2);
    chk("tx_req done", o_tx_req, 9'h000);
  endtask : t_legacy_tx

  // Mask bit set means compare that id bit
  task automatic t_legacy_rx();
    wr(OFF_MASK0, 32'h1fff_ffff);
    wr(OFF_MASK1, 32'h1fff_ffff);
    for (int n = 0; n < 6; n++) wr(FILT + 12'(4 * n), 32'h100 + n);
    for (int n = 0; n < 6; n++) begin
      put(29'h100 + 29'(n), 1'b0, 1'b0);
      chk("rx_full", o_rx_full, (n < 2) ? 8'h01 : 8'h02);
      wr(OFF_RXFULL, 32'hff);
    end
    put(29'h155, 1'b0, 1'b0);
    chk("no hit", o_rx_full, 8'h00);
    put(29'h100, 1'b0, 1'b1);
    chk("err dropped", o_rx_full, 8'h00);
    wr(OFF_RXCTL, 32'h3);
    put(29'h155, 1'b0, 1'b1);
    chk("accept any", o_rx_full, 8'h01);
    wr(OFF_RXFULL, 32'hff);
    // Accept-all on the second receive buffer alone
    wr(OFF_RXCTL, 32'hc);
    put(29'h155, 1'b0, 1'b1);
    chk("accept any 1", o_rx_full, 8'h02);
    wr(OFF_RXFULL, 32'hff);
    wr(OFF_RXCTL, 32'h0);
  endtask : t_legacy_rx

  // Full buffer back-pressures the FIFO, then drains one per clear
  task automatic t_fifo();
    int cnt;
    bit ok;
    cnt = 0;
    ok = 1'b1;
    while (ok && cnt < 40) begin
      node_u.send('{rtr: 1'b0, err: 1'b0, dlc: 4'h1, id: 29'h100}, 6, ok);
      if (ok) cnt++;
    end
    chk("accepted", cnt, 1 + FIFO_DEPTH);
    for (int i = 0; i <= FIFO_DEPTH; i++) begin
      tick(1);
      chk("rx0 held", o_rx_full[0], 1'b1);
      wr(OFF_RXFULL, 32'h1);
      tick(3);
    end
    chk("drained", o_rx_full, 8'h00);
    chk("ready", o_frame_ready, 1'b1);
  endtask : t_fifo

  task automatic t_enhanced();
    logic [31:0] d;
    logic [1:0] r;
    wr(OFF_MODE, 32'h1);
    tick(1);
    chk("o_mode", o_mode, 2'h1);
    wr(FILT + 12'h038, 32'h1abcdef);
    axi_rd(FILT + 12'h038, d, r);
    chk("filter14", d, 32'h1abcdef);
    // Extra 0 receives, extra 1 transmits and answers remote frames
    wr(OFF_BUFCFG, 32'h0202);
    wr(FILT + 12'h028, 32'h300);
    wr(FILT + 12'h02c, 32'h301);
    wr(LINK + 12'h028, 32'h02);
    wr(LINK + 12'h02c, 32'h02);
    for (int n = 0; n < 2; n++) begin
      put(29'h300 + 29'(n), 1'b0, 1'b0);
      chk("extra0", o_rx_full, 8'h04);
      wr(OFF_RXFULL, 32'hff);
    end
    // Last store came through filter 11 with length code 2
    axi_rd(12'h0c8, d, r);
    chk("bufid2", d, 32'h301);
    axi_rd(OFF_STAT, d, r);
    chk("stat", d, 32'h4b);
    // Filter 15 as a zero mask lets filter 12 pass any id
    wr(OFF_MODE, 32'h11);
    wr(FILT + 12'h03c, 32'h0);
    wr(FILT + 12'h030, 32'h7ff);
    wr(LINK + 12'h030, 32'h12);
    put(29'h5a5, 1'b0, 1'b0);
    chk("f15 mask", o_rx_full, 8'h04);
    wr(OFF_RXFULL, 32'hff);
    // Filter 7 sits below catch-all filter 12, so it wins
    wr(FILT + 12'h01c, 32'h302);
    wr(LINK + 12'h01c, 32'h03);
    put(29'h302, 1'b1, 1'b0);
    chk("auto answer", o_tx_req, 9'h010);
    chk("tx owned", o_rx_full, 8'h00);
    node_u.tx_finish(9'h010);
    wr(OFF_TXREQ, 32'h010);
    tick(2);
    chk("extra tx", o_tx_req, 9'h010);
    node_u.tx_finish(9'h010);
    tick(2);
    chk("extra done", o_tx_req, 9'h000);
    wr(OFF_MODE, 32'h2);
    put(29'h300, 1'b0, 1'b0);
    chk("mode2 mode", o_mode, 2'h2);
    chk("mode2 rx", o_rx_full, 8'h04);
  endtask : t_enhanced

  // Reset in mid-run returns to mode zero
  task automatic t_rereset();
    logic [31:0] d;
    logic [1:0] r;
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    tick(2);
    chk("o_mode", o_mode, 2'h0);
    chk("rx_full", o_rx_full, 8'h00);
    axi_rd(OFF_MODE, d, r);
    chk("mode reg", d, 32'h0);
  endtask : t_rereset

  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    tick(2);
    t_reset_map();
    t_legacy_tx();
    t_legacy_rx();
    t_fifo();
    t_enhanced();
    t_rereset();
    test_done();
  end
endmodule : tb
